// File: common/bdm_map.svh
/*
  offsets, field positions and reset values of the banked data memory
  assumes: included by the core; definitions only
*/
`ifndef BDM_MAP_SVH
`define BDM_MAP_SVH
`define BDM_ADDR_W 12
`define BDM_BANK_W 4
`define BDM_FILE_W 8
`define BDM_SFR_BASE 12'hF60
`define BDM_GPR_TOP_SMALL 12'h7FF
`define BDM_GPR_TOP_LARGE 12'hEFF
`define BDM_ACCESS_SPLIT 8'h60
`define BDM_BANK_TOP 4'hF
`define BDM_PTR2_LOW 12'hFD9
`define BDM_PTR2_HIGH 12'hFDA
`define BDM_IND2_PLUSW 12'hFDB
`define BDM_IND2_PREINC 12'hFDC
`define BDM_IND2_POSTDEC 12'hFDD
`define BDM_IND2_POSTINC 12'hFDE
`define BDM_IND2_OPERAND 12'hFDF
`define BDM_BANK_SELECT 12'hFE0
`define BDM_PTR1_LOW 12'hFE1
`define BDM_PTR1_HIGH 12'hFE2
`define BDM_IND1_PLUSW 12'hFE3
`define BDM_IND1_PREINC 12'hFE4
`define BDM_IND1_POSTDEC 12'hFE5
`define BDM_IND1_POSTINC 12'hFE6
`define BDM_IND1_OPERAND 12'hFE7
`define BDM_PTR0_LOW 12'hFE9
`define BDM_PTR0_HIGH 12'hFEA
`define BDM_IND0_PLUSW 12'hFEB
`define BDM_IND0_PREINC 12'hFEC
`define BDM_IND0_POSTDEC 12'hFED
`define BDM_IND0_POSTINC 12'hFEE
`define BDM_IND0_OPERAND 12'hFEF
`define BDM_PDATA_LATCH 12'hFF5
`define BDM_PPTR_LOW 12'hFF6
`define BDM_PPTR_HIGH 12'hFF7
`define BDM_PPTR_UPPER 12'hFF8
`define BDM_RESET_BYTE 8'h00
`endif

// File: common/bdm_pkg.sv
/*
  types of the banked data memory
  assumes: nothing beyond the map header
*/
package bdm_pkg;
  typedef enum logic [1:0] {
    BDM_Q1 = 2'b00,
    BDM_Q2 = 2'b01,
    BDM_Q3 = 2'b11,
    BDM_Q4 = 2'b10
  } bdm_phase_e;
  typedef enum logic [2:0] {
    BDM_IND_NONE = 3'h0,
    BDM_IND_PLAIN = 3'h1,
    BDM_IND_POSTINC = 3'h2,
    BDM_IND_POSTDEC = 3'h3,
    BDM_IND_PREINC = 3'h4,
    BDM_IND_PLUSW = 3'h5
  } bdm_ind_e;
  typedef logic [11:0] bdm_addr_t;
endpackage

// File: core/bdm_core.sv
/*
  banked data memory, core pointers and program table path
  assumes: the cpu core gives one access per four-phase instruction cycle
*/
`timescale 1ns/100ps
`include "bdm_map.svh"

module bdm_core #(
  parameter bit LARGE_RAM = 1'b1
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic acc_valid,
  input wire logic [7:0] acc_file,
  input wire logic acc_use_access,
  input wire logic acc_move,
  input wire logic [11:0] acc_move_src,
  input wire logic [11:0] acc_move_dst,
  input wire logic acc_write,
  input wire logic [7:0] acc_wdata,
  input wire logic [7:0] wreg,
  output logic [7:0] acc_rdata,
  output logic acc_done,
  output logic [1:0] phase,
  input wire logic tbl_read,
  input wire logic tbl_write,
  input wire logic [1:0] tbl_ptr_step,
  output logic [21:0] prog_addr,
  output logic prog_rd,
  output logic prog_wr,
  output logic [7:0] prog_wdata,
  input wire logic [7:0] prog_rdata
);

  // ---------------------------------------------
  // instruction phase
  // ---------------------------------------------
  bdm_pkg::bdm_phase_e phase_reg;
  logic move_second_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_reg <= bdm_pkg::BDM_Q1;
    end else begin
      case (phase_reg)
        bdm_pkg::BDM_Q1: phase_reg <= bdm_pkg::BDM_Q2;
        bdm_pkg::BDM_Q2: phase_reg <= bdm_pkg::BDM_Q3;
        bdm_pkg::BDM_Q3: phase_reg <= bdm_pkg::BDM_Q4;
        bdm_pkg::BDM_Q4: phase_reg <= bdm_pkg::BDM_Q1;
        default: phase_reg <= bdm_pkg::BDM_Q1;
      endcase
    end
  end
  assign phase = phase_reg;
  logic in_q2;
  logic in_q4;
  assign in_q2 = (phase_reg == bdm_pkg::BDM_Q2);
  assign in_q4 = (phase_reg == bdm_pkg::BDM_Q4);

  // ---------------------------------------------
  // core registers
  // ---------------------------------------------
  logic [3:0] bank_select_reg;
  logic [11:0] ptr_reg [3];
  logic [7:0] pdata_latch_reg;
  logic [21:0] pptr_reg;
  logic [7:0] ram [4096];

  // ---------------------------------------------
  // address formation
  // ---------------------------------------------
  logic [11:0] direct_addr;
  logic access_top;
  assign access_top = (acc_file >= `BDM_ACCESS_SPLIT);
  always_comb begin
    if (acc_use_access) begin
      // access bank: low part of bank 0, top part of bank 15
      direct_addr = access_top ? {`BDM_BANK_TOP, acc_file} : {4'h0, acc_file};
    end else begin
      direct_addr = {bank_select_reg, acc_file};
    end
  end

  // ---------------------------------------------
  // move sequencing
  // ---------------------------------------------
  // move is a two-cycle op: source in the first, destination in the second
  logic [11:0] named_addr;
  always_comb begin
    if (acc_move) begin
      named_addr = move_second_reg ? acc_move_dst : acc_move_src;
    end else begin
      named_addr = direct_addr;
    end
  end

  // ---------------------------------------------
  // indirect addressing
  // ---------------------------------------------
  // indirect decode
  bdm_pkg::bdm_ind_e ind_kind;
  logic [1:0] ind_sel;
  always_comb begin
    ind_kind = bdm_pkg::BDM_IND_NONE;
    ind_sel = 2'h0;
    case (named_addr)
      `BDM_IND0_OPERAND: ind_kind = bdm_pkg::BDM_IND_PLAIN;
      `BDM_IND0_POSTINC: ind_kind = bdm_pkg::BDM_IND_POSTINC;
      `BDM_IND0_POSTDEC: ind_kind = bdm_pkg::BDM_IND_POSTDEC;
      `BDM_IND0_PREINC: ind_kind = bdm_pkg::BDM_IND_PREINC;
      `BDM_IND0_PLUSW: ind_kind = bdm_pkg::BDM_IND_PLUSW;
      `BDM_IND1_OPERAND: ind_kind = bdm_pkg::BDM_IND_PLAIN;
      `BDM_IND1_POSTINC: ind_kind = bdm_pkg::BDM_IND_POSTINC;
      `BDM_IND1_POSTDEC: ind_kind = bdm_pkg::BDM_IND_POSTDEC;
      `BDM_IND1_PREINC: ind_kind = bdm_pkg::BDM_IND_PREINC;
      `BDM_IND1_PLUSW: ind_kind = bdm_pkg::BDM_IND_PLUSW;
      `BDM_IND2_OPERAND: ind_kind = bdm_pkg::BDM_IND_PLAIN;
      `BDM_IND2_POSTINC: ind_kind = bdm_pkg::BDM_IND_POSTINC;
      `BDM_IND2_POSTDEC: ind_kind = bdm_pkg::BDM_IND_POSTDEC;
      `BDM_IND2_PREINC: ind_kind = bdm_pkg::BDM_IND_PREINC;
      `BDM_IND2_PLUSW: ind_kind = bdm_pkg::BDM_IND_PLUSW;
      default: ind_kind = bdm_pkg::BDM_IND_NONE;
    endcase
    if (named_addr >= `BDM_IND1_PLUSW && named_addr <= `BDM_IND1_OPERAND) begin
      ind_sel = 2'h1;
    end else if (named_addr >= `BDM_IND2_PLUSW && named_addr <= `BDM_IND2_OPERAND) begin
      ind_sel = 2'h2;
    end
  end

  // ---------------------------------------------
  // effective address
  // ---------------------------------------------
  logic [11:0] sel_ptr;
  logic [11:0] eff_addr;
  assign sel_ptr = ptr_reg[ind_sel];
  always_comb begin
    case (ind_kind)
      bdm_pkg::BDM_IND_NONE: eff_addr = named_addr;
      bdm_pkg::BDM_IND_PREINC: eff_addr = sel_ptr + 12'h001;
      bdm_pkg::BDM_IND_PLUSW: eff_addr = sel_ptr + {{4{wreg[7]}}, wreg};
      default: eff_addr = sel_ptr; // full 12-bit pointer, no banking
    endcase
  end

  // ---------------------------------------------
  // implemented space
  // ---------------------------------------------
  logic [11:0] gpr_top;
  logic is_sfr;
  logic is_gpr;
  assign gpr_top = LARGE_RAM ? `BDM_GPR_TOP_LARGE : `BDM_GPR_TOP_SMALL;
  assign is_sfr = (eff_addr >= `BDM_SFR_BASE);
  assign is_gpr = (eff_addr <= gpr_top);

  logic [7:0] rd_value;
  always_comb begin
    rd_value = `BDM_RESET_BYTE;
    if (is_gpr) begin
      rd_value = ram[eff_addr];
    end else if (is_sfr) begin
      case (eff_addr)
        `BDM_BANK_SELECT: rd_value = {4'h0, bank_select_reg};
        `BDM_PTR0_LOW: rd_value = ptr_reg[0][7:0];
        `BDM_PTR0_HIGH: rd_value = {4'h0, ptr_reg[0][11:8]};
        `BDM_PTR1_LOW: rd_value = ptr_reg[1][7:0];
        `BDM_PTR1_HIGH: rd_value = {4'h0, ptr_reg[1][11:8]};
        `BDM_PTR2_LOW: rd_value = ptr_reg[2][7:0];
        `BDM_PTR2_HIGH: rd_value = {4'h0, ptr_reg[2][11:8]};
        `BDM_PDATA_LATCH: rd_value = pdata_latch_reg;
        `BDM_PPTR_LOW: rd_value = pptr_reg[7:0];
        `BDM_PPTR_HIGH: rd_value = pptr_reg[15:8];
        `BDM_PPTR_UPPER: rd_value = {2'h0, pptr_reg[21:16]};
        default: rd_value = `BDM_RESET_BYTE;
      endcase
    end
  end

  // ---------------------------------------------
  // operand read in second phase
  // ---------------------------------------------
  logic [7:0] move_hold_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      acc_rdata <= `BDM_RESET_BYTE;
    end else if (acc_valid && in_q2 && !move_second_reg) begin
      acc_rdata <= rd_value;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      move_hold_reg <= `BDM_RESET_BYTE;
    end else if (acc_valid && acc_move && in_q2 && !move_second_reg) begin
      move_hold_reg <= rd_value;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      move_second_reg <= 1'b0;
    end else if (acc_valid && acc_move && in_q4) begin
      move_second_reg <= !move_second_reg;
    end
  end

  assign acc_done = acc_valid && in_q4 && (!acc_move || move_second_reg);

  // ---------------------------------------------
  // destination write in fourth phase
  // ---------------------------------------------
  logic do_write;
  logic [7:0] wr_value;
  assign do_write = acc_valid && in_q4 && (acc_move ? move_second_reg : acc_write);
  assign wr_value = acc_move ? move_hold_reg : acc_wdata;

  // ---------------------------------------------
  // general purpose ram
  // ---------------------------------------------
  // ram has no reset branch
  always_ff @(posedge clk) begin
    if (do_write && is_gpr) begin
      ram[eff_addr] <= wr_value;
    end
  end

  // ---------------------------------------------
  // bank select
  // ---------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      bank_select_reg <= 4'h0;
    end else if (do_write && eff_addr == `BDM_BANK_SELECT) begin
      bank_select_reg <= wr_value[3:0];
    end
  end

  // ---------------------------------------------
  // pointer registers
  // ---------------------------------------------
  // pointer update: direct writes, else post/pre adjust on indirect access
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_ptr
      localparam logic [11:0] LOW_ADDR = (gi == 0) ? `BDM_PTR0_LOW
                                       : (gi == 1) ? `BDM_PTR1_LOW : `BDM_PTR2_LOW;
      localparam logic [11:0] HIGH_ADDR = LOW_ADDR + 12'h001;
      localparam logic [1:0] IDX = 2'(gi);
      logic hit_ind;
      assign hit_ind = acc_valid && in_q4 && (ind_sel == IDX)
                       && (ind_kind != bdm_pkg::BDM_IND_NONE);
      always_ff @(posedge clk) begin
        if (reset) begin
          ptr_reg[gi] <= 12'h000;
        end else if (do_write && eff_addr == LOW_ADDR) begin
          ptr_reg[gi][7:0] <= wr_value;
        end else if (do_write && eff_addr == HIGH_ADDR) begin
          ptr_reg[gi][11:8] <= wr_value[3:0];
        end else if (hit_ind) begin
          case (ind_kind)
            bdm_pkg::BDM_IND_POSTINC: ptr_reg[gi] <= ptr_reg[gi] + 12'h001;
            bdm_pkg::BDM_IND_POSTDEC: ptr_reg[gi] <= ptr_reg[gi] - 12'h001;
            bdm_pkg::BDM_IND_PREINC: ptr_reg[gi] <= ptr_reg[gi] + 12'h001;
            default: ptr_reg[gi] <= ptr_reg[gi];
          endcase
        end
      end
    end
  endgenerate

  // ---------------------------------------------
  // program table path
  // ---------------------------------------------
  logic tbl_rd_pend_reg;
  logic tbl_op;
  assign tbl_op = tbl_read || tbl_write;
  always_ff @(posedge clk) begin
    if (reset) begin
      pptr_reg <= 22'h000000;
    end else if (do_write && eff_addr == `BDM_PPTR_LOW) begin
      pptr_reg[7:0] <= wr_value;
    end else if (do_write && eff_addr == `BDM_PPTR_HIGH) begin
      pptr_reg[15:8] <= wr_value;
    end else if (do_write && eff_addr == `BDM_PPTR_UPPER) begin
      pptr_reg[21:16] <= wr_value[5:0];
    end else if (tbl_op && in_q4) begin
      // byte pointer steps: 1 = after increment, 2 = after decrement, 3 = pre increment
      case (tbl_ptr_step)
        2'h1: pptr_reg <= pptr_reg + 22'h000001;
        2'h2: pptr_reg <= pptr_reg - 22'h000001;
        default: pptr_reg <= pptr_reg;
      endcase
    end else if (tbl_op && in_q2 && tbl_ptr_step == 2'h3) begin
      pptr_reg <= pptr_reg + 22'h000001;
    end
  end

  // one byte per table op, the full pointer is the byte address
  assign prog_addr = pptr_reg;
  assign prog_rd = tbl_read && phase_reg == bdm_pkg::BDM_Q3;
  assign prog_wr = tbl_write && phase_reg == bdm_pkg::BDM_Q3;
  assign prog_wdata = pdata_latch_reg;

  // ---------------------------------------------
  // program latch
  // ---------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      tbl_rd_pend_reg <= 1'b0;
    end else begin
      tbl_rd_pend_reg <= prog_rd;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      pdata_latch_reg <= `BDM_RESET_BYTE;
    end else if (tbl_rd_pend_reg) begin
      pdata_latch_reg <= prog_rdata;
    end else if (do_write && eff_addr == `BDM_PDATA_LATCH) begin
      pdata_latch_reg <= wr_value;
    end
  end

endmodule

// File: dv/bdm_core_checker.sv
/*
  timing checker of the banked data memory core
  assumes: bound to bdm_core, one clock, phase order Q1 Q2 Q3 Q4
*/
`timescale 1ns/100ps
module bdm_core_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic acc_valid,
  input wire logic acc_move,
  input wire logic [7:0] acc_rdata,
  input wire logic acc_done,
  input wire logic [1:0] phase,
  input wire logic tbl_read,
  input wire logic tbl_write,
  input wire logic [1:0] tbl_ptr_step,
  input wire logic [21:0] prog_addr,
  input wire logic prog_rd,
  input wire logic prog_wr,
  input wire logic [7:0] prog_wdata,
  input wire logic [7:0] prog_rdata
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (reset);
  sequence quarters;
    phase == 2'h0 ##1 phase == 2'h1 ##1 phase == 2'h3 ##1 phase == 2'h2;
  endsequence
  sequence move_start;
    $rose(acc_valid) && acc_move;
  endsequence
  chk_phase_cycle: assert property (phase == 2'h0 |-> quarters ##1 phase == 2'h0)
    else $error("phase order broken");
  chk_done_q4: assert property (acc_done |-> phase == 2'h2 && acc_valid)
    else $error("done outside Q4");
  chk_rdata_q2: assert property ($changed(acc_rdata) |->
    $past(phase) == 2'h1 || $past(reset))
    else $error("read data changed outside Q2");
  chk_single_done: assert property ($rose(acc_valid) && !acc_move |-> ##3 acc_done)
    else $error("single access not done in Q4");
  chk_move_done: assert property (move_start |-> !acc_done [*7] ##1 acc_done)
    else $error("move not done after two cycles");
  chk_prog_rd: assert property (prog_rd == (tbl_read && phase == 2'h3))
    else $error("program read strobe misplaced");
  chk_prog_wr: assert property (prog_wr == (tbl_write && phase == 2'h3))
    else $error("program write strobe misplaced");
  chk_ptr_step: assert property (tbl_read && tbl_ptr_step == 2'h1
    && phase == 2'h2 |=> prog_addr == $past(prog_addr) + 22'h1)
    else $error("table pointer not stepped");
  chk_latch_load: assert property (tbl_read && phase == 2'h2 |=>
    prog_wdata == $past(prog_rdata))
    else $error("table latch missed the program byte");
endmodule
bind bdm_core bdm_core_checker u_bdm_core_checker (.clk, .reset, .acc_valid, .acc_move,
  .acc_rdata, .acc_done, .phase, .tbl_read, .tbl_write, .tbl_ptr_step, .prog_addr, .prog_rd,
  .prog_wr, .prog_wdata, .prog_rdata);

// File: dv/bdm_prog_mem.sv
/*
  program memory model on the table path
  assumes: byte address on prog_addr, strobes high in Q3, byte returned one cycle later
*/
`timescale 1ns/100ps
module bdm_prog_mem (
  input wire logic clk,
  input wire logic [21:0] prog_addr,
  input wire logic prog_rd,
  input wire logic prog_wr,
  input wire logic [7:0] prog_wdata,
  output logic [7:0] prog_rdata
);
  logic [7:0] mem [256];
  logic [7:0] rd_byte;
  logic rd_live;
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h3C;
    end
    rd_byte = 8'h00;
    rd_live = 1'b0;
  end
  // byte stands in the cycle after the strobe, else its inverse
  assign prog_rdata = rd_live ? rd_byte : ~rd_byte;
  always @(posedge clk) begin
    rd_live <= prog_rd;
    if (prog_rd) begin
      rd_byte <= mem[prog_addr[7:0]];
    end
    if (prog_wr) begin
      mem[prog_addr[7:0]] <= prog_wdata;
    end
  end
endmodule

// File: dv/bdm_core_tb_top.sv
/*
  self-checking bench of the banked data memory core
  assumes: large variant, program memory model beside the core
*/
`timescale 1ns/100ps
module bdm_core_tb_top;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic acc_valid = 1'b0;
  logic acc_use_access = 1'b0;
  logic acc_move = 1'b0;
  logic acc_write = 1'b0;
  logic tbl_read = 1'b0;
  logic tbl_write = 1'b0;
  logic [7:0] acc_file = 8'h00;
  logic [7:0] acc_wdata = 8'h00;
  logic [7:0] wreg = 8'h00;
  logic [11:0] acc_move_src = 12'h000;
  logic [11:0] acc_move_dst = 12'h000;
  logic [1:0] tbl_ptr_step = 2'h1;
  logic [7:0] acc_rdata, prog_wdata, prog_rdata, rv;
  logic acc_done, prog_rd, prog_wr;
  logic [1:0] phase;
  logic [21:0] prog_addr;
  int n_fail = 0;
  int checked = 0;
  bdm_core #(.LARGE_RAM(1'b1)) u_bdm_core (.clk, .reset, .acc_valid, .acc_file,
    .acc_use_access, .acc_move, .acc_move_src, .acc_move_dst, .acc_write, .acc_wdata,
    .wreg, .acc_rdata, .acc_done, .phase, .tbl_read, .tbl_write, .tbl_ptr_step,
    .prog_addr, .prog_rd, .prog_wr, .prog_wdata, .prog_rdata);
  bdm_prog_mem u_bdm_prog_mem (.clk, .prog_addr, .prog_rd, .prog_wr, .prog_wdata,
    .prog_rdata);
  initial begin
    forever #4 clk = ~clk;
  end
  task automatic results;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wait_q4;
    int i;
    i = 0;
    do begin
      @(negedge clk);
      i++;
    end while (phase !== 2'h2 && i < 12);
    if (i >= 12) begin
      n_fail++;
      results();
    end
  endtask
  task automatic op(input logic [7:0] f, input logic ua, mv, w, tr, tw, input logic [7:0] d);
    wait_q4();
    @(posedge clk);
    acc_valid <= !(tr || tw);
    acc_file <= f;
    acc_use_access <= ua;
    acc_move <= mv;
    acc_write <= w;
    acc_wdata <= d;
    tbl_read <= tr;
    tbl_write <= tw;
    wait_q4();
    if (mv) begin
      wait_q4();
    end
    @(posedge clk);
    acc_valid <= 1'b0;
    tbl_read <= 1'b0;
    tbl_write <= 1'b0;
    @(negedge clk);
    rv = acc_rdata;
  endtask
  task automatic acc(input logic [11:0] a, input logic w, input logic [7:0] d);
    if (a < 12'hF60) begin
      op(8'hE0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, {4'h0, a[11:8]});
    end
    op(a[7:0], a >= 12'hF60, 1'b0, w, 1'b0, 1'b0, d);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    acc(a, 1'b1, d);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    acc(a, 1'b0, 8'h00);
    chk(rv, exp);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    wr(12'hFE0, 8'hFF);
    rd(12'hFE0, 8'h0F);
    wr(12'h000, 8'hA5);
    wr(12'h7FF, 8'h5A);
    wr(12'hEFF, 8'hC3);
    wr(12'hF00, 8'h77);
    rd(12'h000, 8'hA5);
    rd(12'h7FF, 8'h5A);
    rd(12'hEFF, 8'hC3);
    rd(12'hF00, 8'h00);
    rd(12'hFD4, 8'h00);
    op(8'h10, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 8'h3E);
    rd(12'h010, 8'h3E);
    wr(12'hFE9, 8'h23);
    wr(12'hFEA, 8'hF1);
    rd(12'hFEA, 8'h01);
    wr(12'hFEF, 8'h96);
    rd(12'h123, 8'h96);
    wr(12'hFEE, 8'h69);
    rd(12'hFE9, 8'h24);
    wr(12'hFE9, 8'h00);
    wr(12'hFEA, 8'h00);
    rd(12'hFEF, 8'hA5);
    @(posedge clk);
    acc_move_src <= 12'h123;
    acc_move_dst <= 12'h456;
    op(8'h00, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 8'h00);
    rd(12'h456, 8'h69);
    wr(12'hFF6, 8'h11);
    op(8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    rd(12'hFF5, 8'h11 ^ 8'h3C);
    rd(12'hFF6, 8'h12);
    wr(12'hFF5, 8'hB7);
    op(8'h00, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    chk(u_bdm_prog_mem.mem[8'h12], 8'hB7);
    @(posedge clk);
    tbl_ptr_step <= 2'h3;
    op(8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    rd(12'hFF5, 8'h14 ^ 8'h3C);
    @(posedge clk);
    tbl_ptr_step <= 2'h2;
    op(8'h00, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 8'h00);
    rd(12'hFF6, 8'h13);
    wr(12'hFE1, 8'h40);
    wr(12'hFE2, 8'h02);
    wr(12'hFE4, 8'h5C);
    rd(12'h241, 8'h5C);
    rd(12'hFE1, 8'h41);
    wr(12'hFD9, 8'h10);
    wr(12'hFDA, 8'h03);
    wr(12'hFDD, 8'h4B);
    rd(12'h310, 8'h4B);
    rd(12'hFD9, 8'h0F);
    wr(12'h30D, 8'h81);
    @(posedge clk);
    wreg <= 8'hFE;
    rd(12'hFDB, 8'h81);
    rd(12'hF9C, 8'h00);
    @(posedge clk);
    reset <= 1'b1;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd(12'hFE0, 8'h00);
    rd(12'h000, 8'hA5);
    results();
  end
endmodule
